// file: verilog/smr_pkg.sv
// Shared constants for the synchronous master receive block
package smr_pkg;
  // Word register indices; byte address is four times the index
  localparam logic [5:0] IDX_RX_CTRL = 6'h13;
  localparam logic [5:0] IDX_RX_FIFO = 6'h14;
  localparam logic [5:0] IDX_TX_CTRL = 6'h15;
  localparam logic [5:0] IDX_TX_DATA = 6'h16;
  localparam logic [5:0] IDX_BAUD = 6'h17;
  // Second bank sits above the first
  localparam logic [5:0] BANK1_BASE = 6'h20;
  localparam logic [5:0] IDX_FLAGS = 6'h36;
  localparam logic [5:0] IDX_IRQ_EN = 6'h37;
  // Receive status and control fields
  localparam int RX_PORT_EN = 7;
  localparam int RX_NINE_SEL = 6;
  localparam int RX_SINGLE = 5;
  localparam int RX_CONT = 4;
  localparam int RX_FRAME_ERR = 2;
  localparam int RX_OVERRUN = 1;
  localparam int RX_NINTH = 0;
  // Transmit status and control fields
  localparam int TX_CLK_SRC = 7;
  localparam int TX_NINE_SEL = 6;
  localparam int TX_ENABLE = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_SHIFT_EMPTY = 1;
  localparam int TX_NINTH = 0;
  // Flag and enable fields
  localparam int FLAG_RX_DONE = 0;
  localparam int FLAG_TX_BUF = 1;
  localparam int IEN_RX = 0;
  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h02;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Word lengths
  localparam logic [3:0] BITS_NORMAL = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam int FIFO_DEPTH = 2;
  localparam int ENTRY_W = 10;
  typedef enum logic {ST_IDLE, ST_SHIFT} smr_state_t;
endpackage

// file: verilog/smr_fifo.sv
// Two-entry receive queue holding data, ninth bit and error status
`timescale 1ns/1ps
module smr_fifo #(
  parameter int WIDTH = smr_pkg::ENTRY_W,
  parameter int DEPTH = smr_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rd_r];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // Storage has no reset; out_data shows mem[rd_r] even while the queue is empty
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_depth;
    cnt_r <= (AW+1)'(DEPTH);
  endproperty
  a_depth: assert property (p_depth) else $error("queue over depth");
  property p_full_holds;
    !in_ready && !pop |=> !in_ready;
  endproperty
  a_full_holds: assert property (p_full_holds)
    else $error("full queue lost an entry");
endmodule // smr_fifo

// file: verilog/smr_rx.sv
// Synchronous master serial receive path with register file
//
// Overview of operation
// - Either receive enable starts synchronous reception
// - Sample data on falling shift clock edge
// - Single enable alone receives one word
// - Continuous enable receives until software clears
// - Both enables set behaves as continuous
// - Completed word moves into queue if room
// - Queue transfer sets receive complete flag
// - Interrupt request gated by receive interrupt enable bit
// - Complete flag read only, clears when empty
// - Two entry queue while third shifts
// - Full queue at word end sets overrun
// - Overrun cleared by clearing continuous enable
// - Overrun blocks all transfers into queue
// - Ninth bit and error queued per word
// - Clearing enables or port resets receive logic
// - Nine bit mode shifts nine, stores ninth
// - Warm reset keeps undefined register bits
// - Clock source master drives shift clock out
`timescale 1ns/1ps
module smr_rx (
  // Clock and resets
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic warm_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial pins
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_n,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_n,
  // Interrupt request
  output logic rx_irq
);
  logic rst_s1_r;
  logic rst_n_r;
  logic [7:0] rx_ctrl_r;
  logic [7:0] tx_ctrl_r;
  logic [7:0] tx_data_r;
  logic [7:0] baud_divisor_r;
  logic [7:0] irq_en_r;
  logic overrun_error_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic irq_r;
  logic clk_out_r;
  logic clk_oe_n_r;
  logic data_out_r;
  logic data_oe_n_r;
  smr_pkg::smr_state_t state_r;
  logic [7:0] baud_cnt_r;
  logic [3:0] bit_cnt_r;
  logic [8:0] shift_r;
  logic [7:0] rd_val;
  logic [7:0] rx_ctrl_nxt;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Bus decode
  function automatic logic [7:0] addr_of(input logic [5:0] idx);
    addr_of = {idx, 2'b00};
  endfunction
  wire bus_req = wb_cyc_i && wb_stb_i;
  wire bus_take = bus_req && ack_r;
  wire wr_ok = bus_take && wb_we_i && wb_sel_i[0];
  wire hit_rx_ctrl = wb_adr_i == addr_of(smr_pkg::IDX_RX_CTRL);
  wire hit_rx_fifo = wb_adr_i == addr_of(smr_pkg::IDX_RX_FIFO);
  wire hit_tx_ctrl = wb_adr_i == addr_of(smr_pkg::IDX_TX_CTRL);
  wire hit_tx_data = wb_adr_i == addr_of(smr_pkg::IDX_TX_DATA);
  wire hit_baud = wb_adr_i == addr_of(smr_pkg::IDX_BAUD);
  wire hit_flags = wb_adr_i == addr_of(smr_pkg::IDX_FLAGS);
  wire hit_irq_en = wb_adr_i == addr_of(smr_pkg::IDX_IRQ_EN);
  wire wr_rx_ctrl = wr_ok && hit_rx_ctrl;
  wire wr_irq_en = wr_ok && hit_irq_en;

  // Control fields
  wire port_en = rx_ctrl_r[smr_pkg::RX_PORT_EN];
  wire nine_sel = rx_ctrl_r[smr_pkg::RX_NINE_SEL];
  wire single_receive_enable = rx_ctrl_r[smr_pkg::RX_SINGLE];
  wire continuous_receive_enable = rx_ctrl_r[smr_pkg::RX_CONT];
  wire sync_mode = tx_ctrl_r[smr_pkg::TX_SYNC];
  wire clock_source_select = tx_ctrl_r[smr_pkg::TX_CLK_SRC];
  wire master_on = port_en && sync_mode && clock_source_select;
  wire rx_enable = single_receive_enable ||
                   continuous_receive_enable;
  wire rx_run = master_on && rx_enable;

  // Shift clock timing
  wire baud_tick = baud_cnt_r == baud_divisor_r;
  wire fall = (state_r == smr_pkg::ST_SHIFT) && baud_tick && clk_out_r;
  wire [3:0] word_bits = nine_sel ? smr_pkg::BITS_NINE
                                  : smr_pkg::BITS_NORMAL;
  wire word_done = fall && (bit_cnt_r == word_bits - 4'h1);
  wire [8:0] shift_full = shift_r |
                          (9'(serial_data_pin_i) << bit_cnt_r);

  // Receive queue
  logic q_ready;
  logic q_valid;
  logic [smr_pkg::ENTRY_W-1:0] q_head;
  wire q_push = word_done && !overrun_error_r;
  wire q_pop = bus_take && !wb_we_i && hit_rx_fifo;
  wire overrun_set = word_done && !q_ready &&
                     !overrun_error_r;
  // Framing has no meaning for a clocked link; zero is queued
  wire [smr_pkg::ENTRY_W-1:0] q_entry = {1'b0,
    nine_sel & shift_full[8], shift_full[7:0]};
  wire receive_complete_flag = q_valid;

  smr_fifo #(
    .WIDTH(smr_pkg::ENTRY_W),
    .DEPTH(smr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst_n(rst_n_r),
    .in_valid(q_push && q_ready),
    .in_ready(q_ready),
    .in_data(q_entry),
    .out_valid(q_valid),
    .out_ready(q_pop),
    .out_data(q_head)
  );

  // Software writes, then hardware ends a single reception
  always_comb begin
    rx_ctrl_nxt = rx_ctrl_r;
    if (wr_rx_ctrl) begin
      rx_ctrl_nxt = wb_dat_i[7:0];
    end
    if (word_done && !continuous_receive_enable) begin
      rx_ctrl_nxt[smr_pkg::RX_SINGLE] = 1'b0;
    end
  end

  // Read multiplexer; framing and ninth bits follow the queue head
  wire [7:0] rx_ctrl_rd = {rx_ctrl_r[7:4], 1'b0,
    q_head[9], overrun_error_r, q_head[8]};
  wire [7:0] tx_ctrl_rd = {tx_ctrl_r[7:4], 2'b00, 1'b1,
    tx_ctrl_r[smr_pkg::TX_NINTH]};
  // No transmit path here, so its buffer flag keeps its reset value
  wire [7:0] flags_rd = smr_pkg::FLAGS_RST |
    {7'h00, receive_complete_flag};
  always_comb begin
    if (hit_rx_ctrl) begin
      rd_val = rx_ctrl_rd;
    end else if (hit_rx_fifo) begin
      rd_val = q_head[7:0];
    end else if (hit_tx_ctrl) begin
      rd_val = tx_ctrl_rd;
    end else if (hit_baud) begin
      rd_val = baud_divisor_r;
    end else if (hit_flags) begin
      rd_val = flags_rd;
    end else if (hit_irq_en) begin
      rd_val = irq_en_r;
    end else begin
      rd_val = 8'h00;
    end
  end

  // Bus answer: one wait cycle, then ack for one cycle
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= bus_req && !ack_r;
      dat_r <= {24'h000000, rd_val};
    end
  end

  // Registers; a warm reset keeps the undefined bits
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rx_ctrl_r <= smr_pkg::CTRL_RST;
      tx_ctrl_r <= smr_pkg::CTRL_RST;
      tx_data_r <= 8'h00;
      baud_divisor_r <= 8'h00;
      irq_en_r <= smr_pkg::IRQ_EN_RST;
    end else if (warm_rst) begin
      rx_ctrl_r <= smr_pkg::CTRL_RST;
      tx_ctrl_r[7:4] <= smr_pkg::CTRL_RST[7:4];
      irq_en_r <= smr_pkg::IRQ_EN_RST;
    end else begin
      rx_ctrl_r <= rx_ctrl_nxt;
      if (wr_ok && hit_tx_ctrl) begin
        tx_ctrl_r <= wb_dat_i[7:0];
      end
      if (wr_ok && hit_tx_data) begin
        tx_data_r <= wb_dat_i[7:0];
      end
      if (wr_ok && hit_baud) begin
        baud_divisor_r <= wb_dat_i[7:0];
      end
      if (wr_irq_en) begin
        irq_en_r <= wb_dat_i[7:0];
      end
    end
  end

  // Overrun: a new overrun wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      overrun_error_r <= 1'b0;
    end else if (overrun_set) begin
      overrun_error_r <= 1'b1;
    end else if (warm_rst || !continuous_receive_enable) begin
      overrun_error_r <= 1'b0;
    end
  end

  // Shift engine
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= smr_pkg::ST_IDLE;
      baud_cnt_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      shift_r <= 9'h000;
      clk_out_r <= 1'b0;
    end else begin
      case (state_r)
        smr_pkg::ST_IDLE: begin
          baud_cnt_r <= 8'h00;
          bit_cnt_r <= 4'h0;
          shift_r <= 9'h000;
          clk_out_r <= 1'b0;
          if (rx_run && !warm_rst) begin
            state_r <= smr_pkg::ST_SHIFT;
          end
        end
        smr_pkg::ST_SHIFT: begin
          if (!rx_run || warm_rst) begin
            state_r <= smr_pkg::ST_IDLE;
            clk_out_r <= 1'b0;
          end else if (baud_tick) begin
            baud_cnt_r <= 8'h00;
            clk_out_r <= !clk_out_r;
            if (fall) begin
              if (word_done) begin
                bit_cnt_r <= 4'h0;
                shift_r <= 9'h000;
                if (!continuous_receive_enable) begin
                  state_r <= smr_pkg::ST_IDLE;
                end
              end else begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
                shift_r <= shift_full;
              end
            end
          end else begin
            baud_cnt_r <= baud_cnt_r + 8'h01;
          end
        end
        default: state_r <= smr_pkg::ST_IDLE;
      endcase
    end
  end

  // Pins and interrupt; the data pin is only ever an input here
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_r <= 1'b0;
      clk_oe_n_r <= 1'b1;
      data_out_r <= 1'b0;
      data_oe_n_r <= 1'b1;
    end else begin
      irq_r <= receive_complete_flag && irq_en_r[smr_pkg::IEN_RX];
      clk_oe_n_r <= !master_on;
      data_out_r <= 1'b0;
      data_oe_n_r <= 1'b1;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign rx_irq = irq_r;
  assign serial_clock_pin_o = clk_out_r;
  assign serial_clock_pin_oe_n = clk_oe_n_r;
  assign serial_data_pin_o = data_out_r;
  assign serial_data_pin_oe_n = data_oe_n_r;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_r);
  property p_flag_set;
    q_push && q_ready |=> receive_complete_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  property p_irq_gate;
    ##1 rx_irq == $past(q_valid && irq_en_r[smr_pkg::IEN_RX]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq gate wrong");
  property p_overrun_set;
    word_done && !q_ready && !q_pop |=> overrun_error_r;
  endproperty
  a_overrun_set: assert property (p_overrun_set)
    else $error("overrun missed");
  property p_overrun_block;
    overrun_error_r |=> !$rose(q_valid);
  endproperty
  a_overrun_block: assert property (p_overrun_block)
    else $error("transfer during overrun");
  property p_overrun_clear;
    $fell(overrun_error_r) |-> $past(!continuous_receive_enable || warm_rst);
  endproperty
  a_overrun_clear: assert property (p_overrun_clear)
    else $error("overrun cleared wrongly");
  property p_sample_fall;
    fall && !warm_rst && rx_run |-> clk_out_r ##1 !clk_out_r;
  endproperty
  a_sample_fall: assert property (p_sample_fall)
    else $error("sample off falling edge");
  property p_single_stop;
    word_done && !continuous_receive_enable && !wr_rx_ctrl && !warm_rst
      |=> state_r == smr_pkg::ST_IDLE && !single_receive_enable;
  endproperty
  a_single_stop: assert property (p_single_stop)
    else $error("single reception kept running");
  property p_cont_run;
    word_done && continuous_receive_enable && rx_run && !wr_rx_ctrl &&
      !warm_rst |=> state_r == smr_pkg::ST_SHIFT;
  endproperty
  a_cont_run: assert property (p_cont_run)
    else $error("continuous reception stopped");
  property p_disable_idle;
    !rx_run |=> state_r == smr_pkg::ST_IDLE && !clk_out_r;
  endproperty
  a_disable_idle: assert property (p_disable_idle)
    else $error("receive logic not idled");
  property p_bit_range;
    bit_cnt_r < word_bits || !rx_run;
  endproperty
  a_bit_range: assert property (p_bit_range)
    else $error("bit count past word");
endmodule // smr_rx

// file: tb/smr_peer.sv
// Behavioural serial peripheral that shifts words out to the receiver
`timescale 1ns/1ps
module smr_peer (
  // Shift clock from the master
  input wire logic sclk,
  input wire logic sclk_oe_n,
  // Word length select
  input wire logic nine,
  // Data toward the master and progress counts
  output logic sdata,
  output logic [15:0] words,
  output logic [15:0] falls
);
  logic [8:0] cur;
  logic [3:0] bit_idx;
  logic held;
  initial begin
    words = 16'h0000;
    falls = 16'h0000;
    bit_idx = 4'h0;
    held = 1'b0;
    cur = 9'h0A5;
  end
  // Data moves on the rising edge so it is settled at the falling one
  always @(posedge sclk) begin
    if (!sclk_oe_n) begin
      held = cur[bit_idx];
      bit_idx = bit_idx + 4'h1;
      if (bit_idx == (nine ? 4'h9 : 4'h8)) begin
        bit_idx = 4'h0;
        words = words + 16'h0001;
        cur = 9'h0A5 + words[8:0] * 9'h035;
      end
    end
  end
  always @(negedge sclk) begin
    falls = falls + 16'h0001;
  end
  // Undriven clock means no frame, so the line shows the inverse of the last bit
  assign sdata = sclk_oe_n ? ~held : held;
endmodule // smr_peer

// file: tb/tb_top.sv
// Register level testbench for the synchronous master receive block
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic warm_rst = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, sd_o, sd_oe_n, sc_o, sc_oe_n, rx_irq, peer_sd;
  logic nine = 1'b0;
  logic [15:0] words, falls, f0;
  logic [31:0] rd;
  int err_total = 0;
  int checked = 0;
  int base;

  always #12.5 core_clk = ~core_clk;

  smr_rx i_dut (.core_clk(core_clk), .nrst(nrst), .warm_rst(warm_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .serial_data_pin_i(sd_oe_n ? peer_sd : sd_o),
    .serial_data_pin_o(sd_o), .serial_data_pin_oe_n(sd_oe_n),
    .serial_clock_pin_i(sc_o), .serial_clock_pin_o(sc_o),
    .serial_clock_pin_oe_n(sc_oe_n), .rx_irq(rx_irq));

  smr_peer i_peer (.sclk(sc_o), .sclk_oe_n(sc_oe_n), .nine(nine),
    .sdata(peer_sd), .words(words), .falls(falls));

  function automatic logic [7:0] ra(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction

  function automatic logic [8:0] wv(input int k);
    logic [8:0] kk;
    kk = k[8:0];
    return 9'h0A5 + kk * 9'h035;
  endfunction

  // Low byte and ninth bit of the k-th word the peer sends
  function automatic logic [7:0] wb(input int k);
    logic [8:0] t;
    t = wv(k);
    return t[7:0];
  endfunction

  function automatic logic wn(input int k);
    logic [8:0] t;
    t = wv(k);
    return t[8];
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single cycle: hold everything until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    // No cycle count assumed; only the watchdog ends a missing answer
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(what, {24'h0, e & m}, rd & {24'h0, m});
  endtask

  // Poll the complete flag with a bounded number of reads
  task automatic wait_rx();
    int n;
    n = 0;
    do begin
      bus(1'b0, ra(smr_pkg::IDX_FLAGS), 8'h00);
      n++;
    end while (rd[smr_pkg::FLAG_RX_DONE] !== 1'b1 && n < 100);
    chk("rx complete", 32'h1, {31'h0, rd[smr_pkg::FLAG_RX_DONE]});
  endtask

  initial begin
    #1500000;
    err_total++;
    end_of_test();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rchk("flags rst", ra(smr_pkg::IDX_FLAGS), 8'hFF, 8'h02);
    rchk("ien rst", ra(smr_pkg::IDX_IRQ_EN), 8'hFF, 8'h00);
    rchk("rx ctrl rst", ra(smr_pkg::IDX_RX_CTRL), 8'hFE, 8'h00);
    rchk("unmapped", 8'h00, 8'hFF, 8'h00);
    $display("test reset done");
    // Divisor first, then mode bits, then an enable
    bus(1'b1, ra(smr_pkg::IDX_BAUD), 8'h01);
    bus(1'b1, ra(smr_pkg::IDX_TX_CTRL), 8'h90);
    f0 = falls;
    bus(1'b1, ra(smr_pkg::IDX_RX_CTRL), 8'hA0);
    wait_rx();
    repeat (40) @(posedge core_clk);
    chk("pulses", 32'd8, {16'h0, falls - f0});
    chk("clk idle", 32'h0, {31'h0, sc_o});
    chk("clk driven", 32'h0, {31'h0, sc_oe_n});
    chk("data oe", 32'h1, {31'h0, sd_oe_n});
    chk("data out", 32'h0, {31'h0, sd_o});
    rchk("rx ctrl", ra(smr_pkg::IDX_RX_CTRL), 8'hFE, 8'h80);
    rchk("word0", ra(smr_pkg::IDX_RX_FIFO), 8'hFF, wb(0));
    rchk("flag clr", ra(smr_pkg::IDX_FLAGS), 8'hFF, 8'h02);
    $display("test single done");
    bus(1'b1, ra(smr_pkg::IDX_IRQ_EN), 8'h01);
    bus(1'b1, ra(smr_pkg::IDX_RX_CTRL), 8'hA0);
    wait_rx();
    repeat (2) @(posedge core_clk);
    chk("irq on", 32'h1, {31'h0, rx_irq});
    bus(1'b1, ra(smr_pkg::IDX_IRQ_EN), 8'h00);
    repeat (2) @(posedge core_clk);
    chk("irq masked", 32'h0, {31'h0, rx_irq});
    bus(1'b1, ra(smr_pkg::IDX_FLAGS), 8'h00);
    rchk("flag ro", ra(smr_pkg::IDX_FLAGS), 8'h01, 8'h01);
    rchk("word1", ra(smr_pkg::IDX_RX_FIFO), 8'hFF, wb(1));
    $display("test irq done");
    nine <= 1'b1;
    f0 = falls;
    bus(1'b1, ra(smr_pkg::IDX_RX_CTRL), 8'hE0);
    wait_rx();
    repeat (40) @(posedge core_clk);
    chk("pulses nine", 32'd9, {16'h0, falls - f0});
    rchk("ninth", ra(smr_pkg::IDX_RX_CTRL), 8'hDF,
         {7'h60, wn(2)});
    rchk("word2", ra(smr_pkg::IDX_RX_FIFO), 8'hFF, wb(2));
    $display("test nine done");
    nine <= 1'b0;
    bus(1'b1, ra(smr_pkg::IDX_RX_CTRL), 8'h80);
    base = words;
    bus(1'b1, ra(smr_pkg::IDX_RX_CTRL), 8'hB0);
    while (words < base + 4 && checked < 1000) @(posedge core_clk);
    repeat (8) @(posedge core_clk);
    rchk("overrun", ra(smr_pkg::IDX_RX_CTRL), 8'hDE, 8'h92);
    rchk("fifo a", ra(smr_pkg::IDX_RX_FIFO), 8'hFF, wb(base));
    rchk("fifo b", ra(smr_pkg::IDX_RX_FIFO), 8'hFF, wb(base + 1));
    repeat (40) @(posedge core_clk);
    rchk("blocked", ra(smr_pkg::IDX_FLAGS), 8'hFF, 8'h02);
    bus(1'b1, ra(smr_pkg::IDX_RX_CTRL), 8'h80);
    rchk("ovr clr", ra(smr_pkg::IDX_RX_CTRL), 8'hFE, 8'h80);
    f0 = falls;
    repeat (40) @(posedge core_clk);
    chk("stopped", 32'h0, {16'h0, falls - f0});
    $display("test overrun done");
    @(posedge core_clk);
    warm_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    warm_rst <= 1'b0;
    rchk("baud kept", ra(smr_pkg::IDX_BAUD), 8'hFF, 8'h01);
    rchk("rx ctrl warm", ra(smr_pkg::IDX_RX_CTRL), 8'hFE, 8'h00);
    rchk("tx ctrl warm", ra(smr_pkg::IDX_TX_CTRL), 8'hFF, 8'h02);
    chk("clk released", 32'h1, {31'h0, sc_oe_n});
    $display("test warm done");
    end_of_test();
  end
endmodule // tb_top
